/* hdl/async_serial_pkg.sv */
// Package for the asynchronous serial transceiver: format fields, flags and bit timing constants.
// Assumes a single 100 MHz clock and a 16x bit-rate tick from the internal divider or the external clock pin.
package async_serial_pkg;

  // ---------------------------------------------------------------------------
  // Bit timing
  // ---------------------------------------------------------------------------
  localparam logic [3:0] SAMPLE_PHASE = 4'h7;
  localparam logic [3:0] PHASE_LAST   = 4'hf;
  localparam logic [3:0] PHASE_RESET  = 4'h0;

  // ---------------------------------------------------------------------------
  // Frame format
  // ---------------------------------------------------------------------------
  localparam logic [2:0] LAST_BIT_EIGHT = 3'h7;
  localparam logic [2:0] LAST_BIT_SEVEN = 3'h6;
  localparam logic [2:0] LAST_BIT_FIVE  = 3'h4;
  localparam logic [2:0] BIT_FIRST      = 3'h0;
  localparam logic [7:0] MASK_EIGHT     = 8'hff;
  localparam logic [7:0] MASK_SEVEN     = 8'h7f;
  localparam logic [7:0] MASK_FIVE      = 8'h1f;
  localparam logic       LINE_MARK      = 1'b1;
  localparam logic       LINE_SPACE     = 1'b0;

  // Mode and control fields that software sets while both enables are low.
  typedef struct packed {
    logic seven_bit_length_select;
    logic parity_enable;
    logic five_bit_select;
    logic two_stop_select;
    logic parity_odd_select;
    logic clk_src_bit1;
    logic clk_src_bit0;
  } mode_s;

  typedef struct packed {
    logic tx_empty_flag;
    logic tx_done_flag;
    logic rx_full_flag;
    logic overrun_flag;
    logic framing_flag;
    logic parity_err_flag;
  } status_s;

  // One-cycle clear requests, issued after software has read the flag as 1.
  typedef struct packed {
    logic tx_done_flag;
    logic rx_full_flag;
    logic overrun_flag;
    logic framing_flag;
    logic parity_err_flag;
  } clear_s;

  typedef struct packed {
    logic tx_empty_irq;
    logic tx_done_irq;
    logic rx_full_irq;
    logic rx_error_irq;
  } irq_s;

  localparam status_s STATUS_RESET = 6'h30;

endpackage

/* hdl/async_serial_transceiver.sv */
// Full-duplex asynchronous serial transmitter and receiver with double buffering.
// Assumes control bits come from the CPU on i_clk; line and clock pins are asynchronous.

module async_serial_transceiver #(
  parameter int DIV_WIDTH = 8
) (
  input  wire logic                      i_clk,
  input  wire logic                      i_reset,
  input  wire logic                      i_transmit_enable,
  input  wire logic                      i_rx_enable,
  input  wire async_serial_pkg::mode_s   i_mode,
  input  wire logic                      i_tx_empty_irq_en,
  input  wire logic                      i_tx_done_irq_en,
  input  wire logic                      i_rx_irq_en,
  input  wire logic [DIV_WIDTH-1:0]      i_baud_div,
  input  wire logic                      i_tx_write,
  input  wire logic [7:0]                i_tx_data,
  input  wire async_serial_pkg::clear_s  i_flag_clear,
  input  wire logic                      i_rx_pin,
  input  wire logic                      i_sck_pin,
  output logic                           o_tx_pin,
  output logic                           o_sck_pin,
  output logic                           o_sck_oe,
  output logic [7:0]                     o_rx_data,
  output async_serial_pkg::status_s      o_status,
  output async_serial_pkg::irq_s         o_irq
);

  typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_PARITY, S_STOP} state_e;

  function automatic logic [2:0] last_bit(input async_serial_pkg::mode_s m);
    if (m.five_bit_select) return async_serial_pkg::LAST_BIT_FIVE;
    if (m.seven_bit_length_select) return async_serial_pkg::LAST_BIT_SEVEN;
    return async_serial_pkg::LAST_BIT_EIGHT;
  endfunction

  function automatic logic [7:0] data_mask(input async_serial_pkg::mode_s m);
    if (m.five_bit_select) return async_serial_pkg::MASK_FIVE;
    if (m.seven_bit_length_select) return async_serial_pkg::MASK_SEVEN;
    return async_serial_pkg::MASK_EIGHT;
  endfunction

  // ---------------------------------------------------------------------------
  // Pin synchronisers and 16x tick
  // ---------------------------------------------------------------------------
  logic                 rx_s1_reg;
  logic                 rx_s2_reg;
  logic                 rx_prev_reg;
  logic                 sck_s1_reg;
  logic                 sck_s2_reg;
  logic                 sck_prev_reg;
  logic [DIV_WIDTH-1:0] baud_cnt_reg;
  wire                  ext_clk;
  wire                  tick_int;
  wire                  tick;
  wire                  rx_fall;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      rx_s1_reg    <= async_serial_pkg::LINE_MARK;
      rx_s2_reg    <= async_serial_pkg::LINE_MARK;
      rx_prev_reg  <= async_serial_pkg::LINE_MARK;
      sck_s1_reg   <= 1'b0;
      sck_s2_reg   <= 1'b0;
      sck_prev_reg <= 1'b0;
    end else begin
      rx_s1_reg    <= i_rx_pin;
      rx_s2_reg    <= rx_s1_reg;
      rx_prev_reg  <= rx_s2_reg;
      sck_s1_reg   <= i_sck_pin;
      sck_s2_reg   <= sck_s1_reg;
      sck_prev_reg <= sck_s2_reg;
    end
  end

  // Internal generator gives one tick every i_baud_div + 1 cycles.
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      baud_cnt_reg <= '0;
    end else begin
      baud_cnt_reg <= tick_int ? '0 : baud_cnt_reg + 1'b1;
    end
  end

  assign ext_clk  = i_mode.clk_src_bit1;
  assign tick_int = (baud_cnt_reg == i_baud_div);
  assign tick     = ext_clk ? (sck_s2_reg & ~sck_prev_reg) : tick_int;
  assign rx_fall  = rx_prev_reg & ~rx_s2_reg;

  // ---------------------------------------------------------------------------
  // Flags and buffers
  // ---------------------------------------------------------------------------
  async_serial_pkg::status_s status_reg;
  async_serial_pkg::status_s status_next;
  async_serial_pkg::irq_s    irq_reg;
  logic [7:0]                tx_data_buffer_reg;
  logic [7:0]                rx_data_buffer_reg;
  logic                      tx_load;
  logic                      tx_finish;
  logic                      rx_done;
  logic                      rx_frame_err;
  logic                      rx_par_err;
  wire                       rx_err_any;

  assign rx_err_any = status_reg.overrun_flag | status_reg.framing_flag
                    | status_reg.parity_err_flag;

  // Hardware sets win over software clears in the same cycle.
  always_comb begin
    status_next = status_reg;
    if (i_tx_write) status_next.tx_empty_flag = 1'b0;
    if (tx_load || !i_transmit_enable) status_next.tx_empty_flag = 1'b1;
    if (i_flag_clear.tx_done_flag) status_next.tx_done_flag = 1'b0;
    if (tx_load) status_next.tx_done_flag = 1'b0;
    if (tx_finish) status_next.tx_done_flag = 1'b1;
    if (i_flag_clear.rx_full_flag) status_next.rx_full_flag = 1'b0;
    if (i_flag_clear.overrun_flag) status_next.overrun_flag = 1'b0;
    if (i_flag_clear.framing_flag) status_next.framing_flag = 1'b0;
    if (i_flag_clear.parity_err_flag) status_next.parity_err_flag = 1'b0;
    if (rx_done) begin
      if (status_reg.rx_full_flag) status_next.overrun_flag = 1'b1;
      if (rx_frame_err) status_next.framing_flag = 1'b1;
      if (rx_par_err) status_next.parity_err_flag = 1'b1;
      if (!status_reg.rx_full_flag && !rx_frame_err && !rx_par_err) begin
        status_next.rx_full_flag = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      status_reg <= async_serial_pkg::STATUS_RESET;
      irq_reg    <= '0;
    end else begin
      status_reg           <= status_next;
      irq_reg.tx_empty_irq <= status_next.tx_empty_flag & i_tx_empty_irq_en;
      irq_reg.tx_done_irq  <= status_next.tx_done_flag & i_tx_done_irq_en;
      irq_reg.rx_full_irq  <= status_next.rx_full_flag & i_rx_irq_en;
      irq_reg.rx_error_irq <= (status_next.overrun_flag | status_next.framing_flag
                             | status_next.parity_err_flag) & i_rx_irq_en;
    end
  end

  // ---------------------------------------------------------------------------
  // Transmitter
  // ---------------------------------------------------------------------------
  state_e     tx_state_reg;
  logic [3:0] tx_phase_reg;
  logic [2:0] tx_bit_reg;
  logic       tx_stop2_reg;
  logic [7:0] tx_shift_reg;
  logic       tx_par_reg;
  logic       tx_line_reg;
  logic       sck_reg;
  logic       sck_oe_reg;
  wire        tx_bit_end;
  wire        tx_stop_end;

  assign tx_bit_end  = tick && (tx_phase_reg == async_serial_pkg::PHASE_LAST);
  assign tx_stop_end = tx_bit_end && (tx_state_reg == S_STOP)
                     && (tx_stop2_reg || !i_mode.two_stop_select);
  // A buffer write blocks the load for one cycle so the new word is not lost.
  assign tx_load   = i_transmit_enable && !status_reg.tx_empty_flag && !i_tx_write
                   && ((tx_state_reg == S_IDLE) || tx_stop_end);
  assign tx_finish = tx_stop_end && !tx_load;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      tx_data_buffer_reg <= '0;
    end else if (i_tx_write) begin
      tx_data_buffer_reg <= i_tx_data;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      tx_state_reg <= S_IDLE;
      tx_phase_reg <= async_serial_pkg::PHASE_RESET;
      tx_bit_reg   <= async_serial_pkg::BIT_FIRST;
      tx_stop2_reg <= 1'b0;
      tx_shift_reg <= '0;
      tx_par_reg   <= 1'b0;
    end else if (!i_transmit_enable) begin
      tx_state_reg <= S_IDLE;
    end else if (tx_load) begin
      tx_state_reg <= S_START;
      tx_phase_reg <= async_serial_pkg::PHASE_RESET;
      tx_bit_reg   <= async_serial_pkg::BIT_FIRST;
      tx_stop2_reg <= 1'b0;
      tx_shift_reg <= tx_data_buffer_reg & data_mask(i_mode);
      tx_par_reg   <= ^(tx_data_buffer_reg & data_mask(i_mode)) ^ i_mode.parity_odd_select;
    end else begin
      if (tick) tx_phase_reg <= tx_phase_reg + 1'b1;
      if (tx_bit_end) begin
        unique case (tx_state_reg)
          S_IDLE:   tx_state_reg <= S_IDLE;
          S_START:  tx_state_reg <= S_DATA;
          S_DATA: begin
            tx_bit_reg <= tx_bit_reg + 1'b1;
            if (tx_bit_reg == last_bit(i_mode)) begin
              tx_state_reg <= i_mode.parity_enable ? S_PARITY : S_STOP;
            end
          end
          S_PARITY: tx_state_reg <= S_STOP;
          S_STOP: begin
            tx_stop2_reg <= 1'b1;
            if (tx_stop_end) begin
              tx_state_reg <= S_IDLE;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      tx_line_reg <= async_serial_pkg::LINE_MARK;
      sck_reg     <= 1'b1;
      sck_oe_reg  <= 1'b0;
    end else begin
      unique case (tx_state_reg)
        S_START:  tx_line_reg <= async_serial_pkg::LINE_SPACE;
        S_DATA:   tx_line_reg <= tx_shift_reg[tx_bit_reg];
        S_PARITY: tx_line_reg <= tx_par_reg;
        S_IDLE,
        S_STOP:   tx_line_reg <= async_serial_pkg::LINE_MARK;
      endcase
      sck_reg    <= (tx_phase_reg > async_serial_pkg::SAMPLE_PHASE);
      sck_oe_reg <= !i_mode.clk_src_bit1 && i_mode.clk_src_bit0;
    end
  end

  // ---------------------------------------------------------------------------
  // Receiver
  // ---------------------------------------------------------------------------
  state_e     rx_state_reg;
  logic [3:0] rx_phase_reg;
  logic [2:0] rx_bit_reg;
  logic [7:0] rx_shift_reg;
  logic       rx_parity_bit_reg;
  wire        rx_sample;
  wire [7:0]  rx_data_masked;

  assign rx_sample      = tick && (rx_phase_reg == async_serial_pkg::SAMPLE_PHASE);
  assign rx_data_masked = rx_shift_reg & data_mask(i_mode);
  assign rx_done        = i_rx_enable && rx_sample && (rx_state_reg == S_STOP);
  assign rx_frame_err   = !rx_s2_reg;
  assign rx_par_err     = i_mode.parity_enable
                        && ((^rx_data_masked ^ rx_parity_bit_reg)
                            != i_mode.parity_odd_select);

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      rx_state_reg      <= S_IDLE;
      rx_phase_reg      <= async_serial_pkg::PHASE_RESET;
      rx_bit_reg        <= async_serial_pkg::BIT_FIRST;
      rx_shift_reg      <= '0;
      rx_parity_bit_reg <= 1'b0;
    end else if (!i_rx_enable) begin
      rx_state_reg <= S_IDLE;
    end else begin
      if (tick) rx_phase_reg <= rx_phase_reg + 1'b1;
      unique case (rx_state_reg)
        S_IDLE: begin
          if (rx_fall && !rx_err_any) begin
            rx_state_reg <= S_START;
            rx_phase_reg <= async_serial_pkg::PHASE_RESET;
            rx_bit_reg   <= async_serial_pkg::BIT_FIRST;
            rx_shift_reg <= '0;
          end
        end
        S_START: if (rx_sample) rx_state_reg <= rx_s2_reg ? S_IDLE : S_DATA;
        S_DATA: begin
          if (rx_sample) begin
            rx_shift_reg[rx_bit_reg] <= rx_s2_reg;
            rx_bit_reg               <= rx_bit_reg + 1'b1;
            if (rx_bit_reg == last_bit(i_mode)) begin
              rx_state_reg <= i_mode.parity_enable ? S_PARITY : S_STOP;
            end
          end
        end
        S_PARITY: begin
          if (rx_sample) begin
            rx_parity_bit_reg <= rx_s2_reg;
            rx_state_reg      <= S_STOP;
          end
        end
        S_STOP:  if (rx_sample) rx_state_reg <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      rx_data_buffer_reg <= '0;
    end else if (rx_done && !status_reg.rx_full_flag) begin
      rx_data_buffer_reg <= rx_data_masked;
    end
  end

  assign o_tx_pin  = tx_line_reg;
  assign o_sck_pin = sck_reg;
  assign o_sck_oe  = sck_oe_reg;
  assign o_rx_data = rx_data_buffer_reg;
  assign o_status  = status_reg;
  assign o_irq     = irq_reg;

endmodule

/* verification/async_serial_asserts.sv */
// Port checker for the asynchronous serial transceiver.
// Assumes one clock domain and the active-high asynchronous reset.
module async_serial_asserts (
  input wire logic                     i_clk,
  input wire logic                     i_reset,
  input wire logic                     i_transmit_enable,
  input wire logic                     i_rx_enable,
  input wire async_serial_pkg::mode_s  i_mode,
  input wire logic                     i_tx_empty_irq_en,
  input wire logic                     i_rx_irq_en,
  input wire logic                     i_tx_write,
  input wire logic                     o_tx_pin,
  input wire logic                     o_sck_pin,
  input wire logic                     o_sck_oe,
  input wire logic [7:0]               o_rx_data,
  input wire async_serial_pkg::status_s o_status,
  input wire async_serial_pkg::irq_s   o_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  a_tx_off_empty: assert property (!i_transmit_enable |=> o_status.tx_empty_flag)
    else $error("empty flag not forced while transmitter off");
  a_write_clears: assert property (i_tx_write && i_transmit_enable |=>
    !o_status.tx_empty_flag) else $error("buffer write kept empty flag");
  a_empty_irq: assert property (!$past(i_reset) |-> o_irq.tx_empty_irq ==
    (o_status.tx_empty_flag && $past(i_tx_empty_irq_en))) else $error("empty irq wrong");
  a_rx_full_irq: assert property (!$past(i_reset) |-> o_irq.rx_full_irq ==
    (o_status.rx_full_flag && $past(i_rx_irq_en))) else $error("full irq wrong");
  a_rx_err_irq: assert property (!$past(i_reset) |-> o_irq.rx_error_irq ==
    ((o_status.overrun_flag || o_status.framing_flag || o_status.parity_err_flag)
     && $past(i_rx_irq_en))) else $error("error irq wrong");
  a_clk_out_en: assert property (!$past(i_reset) |-> o_sck_oe ==
    (!$past(i_mode.clk_src_bit1) && $past(i_mode.clk_src_bit0))) else $error("oe wrong");
  a_rx_off_keep: assert property (!i_rx_enable |=> $stable(o_rx_data))
    else $error("buffer changed while receiver off");
  a_idle_mark: assert property (o_status.tx_done_flag && o_status.tx_empty_flag
    |-> o_tx_pin) else $error("line not at mark when idle");
  a_load_start: assert property ($rose(o_status.tx_empty_flag) && i_transmit_enable
    && $past(i_transmit_enable) |-> ##[0:3] !o_tx_pin) else $error("no start bit");
  a_clk_mid_bit: assert property (o_sck_oe && i_transmit_enable && $past(i_transmit_enable)
    && $past(i_transmit_enable, 2) && $changed(o_tx_pin) |-> !o_sck_pin)
    else $error("output clock high at a bit edge");
endmodule

bind async_serial_transceiver async_serial_asserts u_async_serial_asserts (.i_clk, .i_reset,
  .i_transmit_enable, .i_rx_enable, .i_mode, .i_tx_empty_irq_en, .i_rx_irq_en, .i_tx_write,
  .o_tx_pin, .o_sck_pin, .o_sck_oe, .o_rx_data, .o_status, .o_irq);

/* verification/remote_station.sv */
// Remote serial station: sends frames, captures frames, makes a 16x clock.
// Assumes tasks are entered just after a rising edge of i_clk.
module remote_station (
  input  wire logic i_clk,
  input  wire logic i_line,
  output logic      o_line,
  output logic      o_sck
);
  timeunit 1ns;
  timeprecision 1ns;
  int div_cnt = 0;
  initial o_line = 1'b1;
  initial o_sck = 1'b0;

  // The 16x clock never stops, not even while the unit is set up.
  always @(posedge i_clk) begin
    div_cnt <= (div_cnt + 1) % 4;
    if (div_cnt == 3) o_sck <= ~o_sck;
  end

  task automatic send(input logic [7:0] d, input int n, input int pe, input logic p,
                      input logic stop, input int nst, input int bt);
    logic [12:0] f;
    f = '1;
    f[0] = 1'b0;
    for (int i = 0; i < n; i++) f[1+i] = d[i];
    if (pe != 0) f[1+n] = p;
    f[1+n+pe] = stop;
    for (int i = 0; i < 1 + n + pe + nst; i++) begin
      o_line <= f[i];
      repeat (bt) @(posedge i_clk);
    end
    o_line <= 1'b1;
  endtask

  // Returns at the centre of the first stop bit; gap -1 means no start seen.
  task automatic capture(input int n, input int pe, input int bt, output logic [7:0] d,
                         output logic p, output logic s, output bit ok, output int gap);
    d = '0;
    p = 1'b0;
    s = 1'b0;
    ok = 0;
    gap = 0;
    while (i_line === 1'b1 && gap < 20 * bt) begin
      @(posedge i_clk);
      gap++;
    end
    if (gap == 20 * bt) gap = -1;
    repeat (bt / 2) @(posedge i_clk);
    ok = (i_line === 1'b0);
    for (int i = 0; i < n + pe + 1; i++) begin
      repeat (bt) @(posedge i_clk);
      if (i < n) d[i] = i_line;
      else if (i < n + pe) p = i_line;
      else s = i_line;
    end
  endtask
endmodule

/* verification/async_serial_transceiver_bench.sv */
// Self-checking bench for the asynchronous serial transceiver.
// Assumes the remote station model on the line and clock pins.
module async_serial_transceiver_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, tx_en = 1'b0, rx_en = 1'b0, wr = 1'b0;
  logic ie = 1'b1, rx_line, sck, tx_line, sck_out, sck_oe, p, s;
  logic [7:0] div = 8'h01, wdata = 8'h00, rdata, got;
  async_serial_pkg::mode_s   mode = '0;
  async_serial_pkg::clear_s  clr = '0;
  async_serial_pkg::status_s status;
  async_serial_pkg::irq_s    irq;
  async_serial_pkg::mode_s   fmt [6] = '{7'h00, 7'h08, 7'h64, 7'h38, 7'h25, 7'h02};
  int bad_count = 0, n_tests = 0, w;
  bit ok;

  always #5 clk = ~clk;

  async_serial_transceiver u_async_serial_transceiver (.i_clk(clk), .i_reset(rst),
    .i_transmit_enable(tx_en), .i_rx_enable(rx_en), .i_mode(mode), .i_tx_empty_irq_en(ie),
    .i_tx_done_irq_en(ie), .i_rx_irq_en(ie), .i_baud_div(div), .i_tx_write(wr),
    .i_tx_data(wdata), .i_flag_clear(clr), .i_rx_pin(rx_line), .i_sck_pin(sck),
    .o_tx_pin(tx_line), .o_sck_pin(sck_out), .o_sck_oe(sck_oe), .o_rx_data(rdata),
    .o_status(status), .o_irq(irq));
  remote_station u_remote_station (.i_clk(clk), .i_line(tx_line), .o_line(rx_line),
    .o_sck(sck));

  task automatic give_verdict();
    if (bad_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input bit good, input string msg);
    n_tests++;
    if (!good) begin
      $display("FAIL %0t %s", $time, msg);
      bad_count++;
    end
  endtask

  task automatic lim(input bit hit);
    if (hit) begin
      chk(0, "wait limit");
      give_verdict();
    end
  endtask

  function automatic int nb(input async_serial_pkg::mode_s m);
    return m.five_bit_select ? 5 : (m.seven_bit_length_select ? 7 : 8);
  endfunction

  function automatic logic [7:0] mk(input int n);
    return 8'((1 << n) - 1);
  endfunction

  function automatic logic par(input async_serial_pkg::mode_s m, input logic [7:0] d);
    return ^(d & mk(nb(m))) ^ m.parity_odd_select;
  endfunction

  task automatic setup(input async_serial_pkg::mode_s m);
    @(posedge clk) {tx_en, rx_en} <= 2'b00;
    @(posedge clk) mode <= m;
    @(posedge clk) {tx_en, rx_en} <= 2'b11;
  endtask

  task automatic wr1(input logic [7:0] d);
    @(posedge clk) {wr, wdata} <= {1'b1, d};
    @(posedge clk) wr <= 1'b0;
  endtask

  task automatic clear(input async_serial_pkg::clear_s c);
    @(posedge clk) clr <= c;
    @(posedge clk) clr <= '0;
  endtask

  task automatic rx(input logic [7:0] d, input logic stop, input logic flip);
    u_remote_station.send(d, nb(mode), mode.parity_enable, par(mode, d) ^ flip, stop,
                          1 + mode.two_stop_select, 32);
    repeat (4) @(posedge clk);
  endtask

  // Sends d and receives its inverse at the same time.
  task automatic duplex(input async_serial_pkg::mode_s m, input logic [7:0] d, input int bt);
    int n;
    n = nb(m);
    wr1(d);
    fork
      u_remote_station.capture(n, m.parity_enable, bt, got, p, s, ok, w);
      u_remote_station.send(~d, n, m.parity_enable, par(m, ~d), 1'b1, 1 + m.two_stop_select, bt);
    join
    lim(w < 0);
    repeat (bt) @(posedge clk);
    chk(ok && got === (d & mk(n)) && s === 1'b1, "tx frame");
    chk(m.parity_enable == 0 || p === par(m, d), "tx parity");
    chk(rdata === (~d & mk(n)) && status.rx_full_flag === 1'b1, "rx data");
    chk(irq.rx_full_irq === 1'b1 && irq.tx_done_irq === 1'b1, "irq");
    chk(sck_oe === (m.clk_src_bit0 & ~m.clk_src_bit1), "clock pin enable");
    clear(5'h18);
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(status === async_serial_pkg::STATUS_RESET && rdata === 8'h00, "reset values");
    // Five frame formats on the internal clock, then the external 16x clock.
    for (int i = 0; i < 6; i++) begin
      setup(fmt[i]);
      duplex(fmt[i], 8'h5a ^ 8'(i * 37), fmt[i].clk_src_bit1 ? 128 : 32);
    end
    setup(7'h00);
    wr1(8'hc3);
    repeat (2) @(posedge clk);
    for (w = 0; w < 50 && status.tx_empty_flag !== 1'b1; w++) @(posedge clk);
    lim(w == 50);
    wr1(8'h96);
    u_remote_station.capture(8, 0, 32, got, p, s, ok, w);
    u_remote_station.capture(8, 0, 32, got, p, s, ok, w);
    chk(w >= 0 && w <= 20 && got === 8'h96, "no back-to-back frame");
    rx(8'h11, 1'b1, 1'b0);
    rx(8'h22, 1'b1, 1'b0);
    chk(status.overrun_flag === 1'b1 && rdata === 8'h11, "overrun");
    rx(8'h33, 1'b1, 1'b0);
    chk(rdata === 8'h11 && status.rx_full_flag === 1'b1, "refused after error");
    clear(5'h0c);
    rx(8'h44, 1'b0, 1'b0);
    chk(status.framing_flag === 1'b1 && rdata === 8'h44, "framing");
    chk(status.rx_full_flag === 1'b0 && irq.rx_error_irq === 1'b1, "framing full");
    clear(5'h02);
    setup(7'h20);
    rx(8'h55, 1'b1, 1'b1);
    chk(status.parity_err_flag === 1'b1 && rdata === 8'h55, "parity");
    clear(5'h01);
    rx(8'h66, 1'b1, 1'b0);
    @(posedge clk) rx_en <= 1'b0;
    repeat (4) @(posedge clk);
    chk(status.rx_full_flag === 1'b1 && rdata === 8'h66, "receiver off");
    @(posedge clk) tx_en <= 1'b0;
    wr1(8'h77);
    repeat (3) @(posedge clk);
    chk(status.tx_empty_flag === 1'b1, "empty not forced");
    @(posedge clk) tx_en <= 1'b1;
    repeat (64) @(posedge clk);
    chk(tx_line === 1'b1, "line left mark");
    give_verdict();
  end
endmodule
